// *** slpc_regs.vh ***
// Shared constants of the link power and configuration block
`ifndef SLPC_REGS_VH
`define SLPC_REGS_VH

// Clock and word geometry
`define SLPC_CLK_NS        8
`define SLPC_DW            24
`define SLPC_FW            28
`define SLPC_SW            26
`define SLPC_SHUF_STEP     7
`define SLPC_HALF          5'h0C
`define SLPC_FULL          5'h18

// Frame layout: embedded clock on top, shuffled payload below
`define SLPC_C1            27
`define SLPC_C0            26
`define SLPC_PRE_DCB       24
`define SLPC_PRE_DCA       25

// Scrambler feedback taken from the previous scrambled word
`define SLPC_MIX(x)        ({x[22:0], x[23]} ^ {x[4:0], x[23:5]})

// Timing figures and event counts
`define SLPC_TX_STOP_NS    334
`define SLPC_RX_STOP_NS    200
`define SLPC_TX_LOCK_EDGES 6'h20
`define SLPC_RX_LOCK_WORDS 6'h10
`define SLPC_CNT_W         6

// Transmit configuration word
`define SLPC_TXW           2
`define SLPC_TX_SWING      0
`define SLPC_TX_EDGE       1

// Receive configuration word
`define SLPC_RXW           13
`define SLPC_RX_EQ_ON      0
`define SLPC_RX_EQ_LO      1
`define SLPC_RX_EQ_HI      3
`define SLPC_RX_SSC_LO     4
`define SLPC_RX_SSC_HI     7
`define SLPC_RX_DSLEW      8
`define SLPC_RX_CSLEW      9
`define SLPC_RX_OSS        10
`define SLPC_RX_EDGE       11
`define SLPC_RX_TEST       12

// Power states shared by both ends
`define SLPC_ST_OFF        2'h0
`define SLPC_ST_SLEEP      2'h1
`define SLPC_ST_LOCK       2'h2
`define SLPC_ST_RUN        2'h3

// Synchronised pin indices
`define SLPC_PIN_TXPD      0
`define SLPC_PIN_RXPD      1
`define SLPC_PIN_PCLK      2
`define SLPC_PIN_EQS       3
`define SLPC_PIN_N         4

`endif

// *** slpc_enc.v ***
// Transmit word encoder: scramble, balance, shuffle
`timescale 1ns/1ps
`default_nettype none
`include "slpc_regs.vh"
module slpc_enc (
   input  wire [`SLPC_DW-1:0] data_i,
   input  wire [`SLPC_DW-1:0] prev_i,
   input  wire                rd_i,
   output wire [`SLPC_FW-1:0] frame_o,
   output wire [`SLPC_DW-1:0] scr_o,
   output reg                 rd_o
);
   wire [`SLPC_DW-1:0] mix;
   wire [`SLPC_DW-1:0] bal;
   wire [`SLPC_SW-1:0] pre;
   wire [`SLPC_SW-1:0] sh;
   reg  [4:0]          ones;
   reg  [4:0]          bal_ones;
   reg                 inv;
   integer             i;

   // Step one: self-synchronising scramble, no shared seed needed
   assign mix   = `SLPC_MIX(prev_i);
   assign scr_o = data_i ^ mix;

   // Step two: invert when the word would grow the running disparity
   always @* begin
      ones = 5'h00;
      for (i = 0; i < `SLPC_DW; i = i + 1) begin
         ones = ones + {4'h0, scr_o[i]};
      end
      inv      = rd_i ? (ones > `SLPC_HALF) : (ones < `SLPC_HALF);
      bal_ones = inv ? (`SLPC_FULL - ones) : ones;
      if (bal_ones > `SLPC_HALF) begin
         rd_o = 1'b1;
      end else if (bal_ones < `SLPC_HALF) begin
         rd_o = 1'b0;
      end else begin
         rd_o = rd_i;
      end
   end
   assign bal = inv ? ~scr_o : scr_o;
   assign pre = {^{bal, inv}, inv, bal};

   // Step three: fixed shuffle, step coprime with the payload width
   genvar g;
   generate
      for (g = 0; g < `SLPC_SW; g = g + 1) begin : shuf
         assign sh[g] = pre[(g * `SLPC_SHUF_STEP) % `SLPC_SW];
      end
   endgenerate

   // Embedded clock pair: one then zero
   assign frame_o = {1'b1, 1'b0, sh};
endmodule
`default_nettype wire

// *** slpc_cfg.v ***
// Strap or register configuration word with register precedence
`timescale 1ns/1ps
`default_nettype none
`include "slpc_regs.vh"
module slpc_cfg #(
   parameter W = 2
) (
   input  wire         mclk_i,
   input  wire         nrst_i,
   input  wire         clear_i,
   input  wire [W-1:0] strap_i,
   input  wire         wr_i,
   input  wire [W-1:0] wdata_i,
   output reg  [W-1:0] val_o
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   reg [W-1:0] filt_r;
   reg [W-1:0] shadow_r;
   reg         override_r;

   // Strap pins: three stages, change taken once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : sync
         always @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               s1_r[g]   <= 1'b0;
               s2_r[g]   <= 1'b0;
               s3_r[g]   <= 1'b0;
               filt_r[g] <= 1'b0;
            end else begin
               s1_r[g] <= strap_i[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  filt_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   // Register copy wins once written; clear returns to strap control
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shadow_r   <= {W{1'b0}};
         override_r <= 1'b0;
         val_o      <= {W{1'b0}};
      end else begin
         if (clear_i) begin
            shadow_r   <= {W{1'b0}};
            override_r <= 1'b0;
         end else if (wr_i) begin
            shadow_r   <= wdata_i;
            override_r <= 1'b1;
         end
         val_o <= override_r ? shadow_r : filt_r;
      end
   end
endmodule
`default_nettype wire

// *** slpc_top.v ***
// Link pair power, sleep, coding and configuration control
`timescale 1ns/1ps
`default_nettype none
`include "slpc_regs.vh"
module slpc_top (
   input  wire                 mclk_i,
   input  wire                 nrst_i,
   input  wire                 tx_power_down_n_i,
   input  wire                 parallel_in_clock_i,
   input  wire [`SLPC_DW-1:0]  tx_data_i,
   input  wire                 tx_swing_select_i,
   input  wire                 tx_edge_select_i,
   input  wire                 tx_cfg_wr_i,
   input  wire [`SLPC_TXW-1:0] tx_cfg_wdata_i,
   input  wire                 rx_power_down_n_i,
   input  wire [`SLPC_FW-1:0]  rx_word_i,
   input  wire                 rx_word_strobe_i,
   input  wire                 rx_eq_stream_i,
   input  wire [3:0]           rx_equaliser_gain_i,
   input  wire [3:0]           rx_spread_select_i,
   input  wire                 rx_data_slew_select_i,
   input  wire                 rx_clock_slew_select_i,
   input  wire                 rx_output_state_select_i,
   input  wire                 rx_edge_select_i,
   input  wire                 rx_test_enable_i,
   input  wire                 rx_cfg_wr_i,
   input  wire [`SLPC_RXW-1:0] rx_cfg_wdata_i,
   output reg  [`SLPC_FW-1:0]  tx_frame_o,
   output reg                  tx_frame_valid_o,
   output reg                  tx_out_p_o,
   output reg                  tx_out_n_o,
   output reg                  tx_swing_select_o,
   output reg  [1:0]           tx_state_o,
   output reg  [`SLPC_DW-1:0]  rx_data_o,
   output reg                  rx_data_oe_o,
   output reg                  recovered_out_clock_o,
   output reg                  rx_clock_oe_o,
   output reg                  rx_lock_o,
   output reg                  rx_lock_oe_o,
   output reg                  rx_eq_enable_o,
   output reg  [2:0]           rx_eq_step_o,
   output reg                  rx_data_slew_select_o,
   output reg                  rx_clock_slew_select_o,
   output reg  [3:0]           rx_output_spread_generator_o,
   output reg                  serial_test_out_o,
   output reg  [1:0]           rx_state_o
);
   localparam integer TX_STOP_CYC = (`SLPC_TX_STOP_NS + `SLPC_CLK_NS - 1) / `SLPC_CLK_NS;
   localparam integer RX_STOP_CYC = (`SLPC_RX_STOP_NS + `SLPC_CLK_NS - 1) / `SLPC_CLK_NS;

   wire [`SLPC_PIN_N-1:0] pin_raw;
   reg  [`SLPC_PIN_N-1:0] p1_r;
   reg  [`SLPC_PIN_N-1:0] p2_r;
   reg  [`SLPC_PIN_N-1:0] p3_r;
   reg  [`SLPC_PIN_N-1:0] pin_r;
   reg  [`SLPC_DW-1:0]    d1_r;
   reg  [`SLPC_DW-1:0]    d2_r;
   reg                    pclk_prev_r;
   wire [`SLPC_TXW-1:0]   tx_cfg;
   wire [`SLPC_RXW-1:0]   rx_cfg;
   wire                   rx_clear;

   // Pins from outside: three stages, change taken once two and three agree
   assign pin_raw = {rx_eq_stream_i, parallel_in_clock_i, rx_power_down_n_i, tx_power_down_n_i};
   genvar g;
   generate
      for (g = 0; g < `SLPC_PIN_N; g = g + 1) begin : psync
         always @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               p1_r[g]  <= 1'b0;
               p2_r[g]  <= 1'b0;
               p3_r[g]  <= 1'b0;
               pin_r[g] <= 1'b0;
            end else begin
               p1_r[g] <= pin_raw[g];
               p2_r[g] <= p1_r[g];
               p3_r[g] <= p2_r[g];
               if (p2_r[g] == p3_r[g]) begin
                  pin_r[g] <= p3_r[g];
               end
            end
         end
      end
   endgenerate

   // Data lags two stages, two fewer than the clock's four through the pin filter
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         d1_r        <= {`SLPC_DW{1'b0}};
         d2_r        <= {`SLPC_DW{1'b0}};
         pclk_prev_r <= 1'b0;
      end else begin
         d1_r        <= tx_data_i;
         d2_r        <= d1_r;
         pclk_prev_r <= pin_r[`SLPC_PIN_PCLK];
      end
   end

   // Configuration words; transmit copy is never cleared by sleep
   slpc_cfg #(.W(`SLPC_TXW)) u_tx_cfg (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .clear_i (1'b0),
      .strap_i ({tx_edge_select_i, tx_swing_select_i}),
      .wr_i    (tx_cfg_wr_i),
      .wdata_i (tx_cfg_wdata_i),
      .val_o   (tx_cfg)
   );

   slpc_cfg #(.W(`SLPC_RXW)) u_rx_cfg (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .clear_i (rx_clear),
      .strap_i ({rx_test_enable_i, rx_edge_select_i, rx_output_state_select_i, rx_clock_slew_select_i,
                 rx_data_slew_select_i, rx_spread_select_i, rx_equaliser_gain_i}),
      .wr_i    (rx_cfg_wr_i),
      .wdata_i (rx_cfg_wdata_i),
      .val_o   (rx_cfg)
   );

   // ---- Transmit side ----
   wire                  pclk_f;
   wire                  pclk_edge;
   wire                  cap_edge;
   wire [`SLPC_FW-1:0]   enc_frame;
   wire [`SLPC_DW-1:0]   enc_scr;
   wire                  enc_rd;
   reg  [`SLPC_DW-1:0]   tx_prev_r;
   reg                   tx_rd_r;
   reg  [`SLPC_CNT_W-1:0] tx_gap_r;
   reg  [`SLPC_CNT_W-1:0] tx_lock_r;
   reg  [`SLPC_FW-1:0]   tx_sh_r;
   reg  [1:0]            tx_nxt;

   assign pclk_f    = pin_r[`SLPC_PIN_PCLK];
   assign pclk_edge = pclk_f ^ pclk_prev_r;
   // Rising edge when select high, falling when low
   assign cap_edge  = tx_cfg[`SLPC_TX_EDGE] ? (pclk_f & ~pclk_prev_r) : (~pclk_f & pclk_prev_r);

   slpc_enc u_enc (
      .data_i  (d2_r),
      .prev_i  (tx_prev_r),
      .rd_i    (tx_rd_r),
      .frame_o (enc_frame),
      .scr_o   (enc_scr),
      .rd_o    (enc_rd)
   );

   // Transmit power state: off, sleeping, locking, running
   always @* begin
      tx_nxt = tx_state_o;
      if (!pin_r[`SLPC_PIN_TXPD]) begin
         tx_nxt = `SLPC_ST_OFF;
      end else begin
         case (tx_state_o)
            `SLPC_ST_OFF:   tx_nxt = `SLPC_ST_LOCK;
            `SLPC_ST_SLEEP: if (pclk_edge) tx_nxt = `SLPC_ST_LOCK;
            `SLPC_ST_LOCK: begin
               if (tx_gap_r == TX_STOP_CYC[`SLPC_CNT_W-1:0]) begin
                  tx_nxt = `SLPC_ST_SLEEP;
               end else if (tx_lock_r == `SLPC_TX_LOCK_EDGES) begin
                  tx_nxt = `SLPC_ST_RUN;
               end
            end
            `SLPC_ST_RUN: if (tx_gap_r == TX_STOP_CYC[`SLPC_CNT_W-1:0]) tx_nxt = `SLPC_ST_SLEEP;
            default:      tx_nxt = `SLPC_ST_OFF;
         endcase
      end
   end

   // Gap counter finds a static or too slow clock; lock counter counts clean edges
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_state_o        <= `SLPC_ST_OFF;
         tx_gap_r          <= {`SLPC_CNT_W{1'b0}};
         tx_lock_r         <= {`SLPC_CNT_W{1'b0}};
         tx_prev_r         <= {`SLPC_DW{1'b0}};
         tx_rd_r           <= 1'b0;
         tx_sh_r           <= {`SLPC_FW{1'b0}};
         tx_frame_o        <= {`SLPC_FW{1'b0}};
         tx_frame_valid_o  <= 1'b0;
         tx_out_p_o        <= 1'b1;
         tx_out_n_o        <= 1'b1;
         tx_swing_select_o <= 1'b0;
      end else begin
         tx_state_o        <= tx_nxt;
         tx_swing_select_o <= tx_cfg[`SLPC_TX_SWING];
         tx_frame_valid_o  <= 1'b0;
         if (pclk_edge || tx_state_o == `SLPC_ST_OFF) begin
            tx_gap_r <= {`SLPC_CNT_W{1'b0}};
         end else if (tx_gap_r != TX_STOP_CYC[`SLPC_CNT_W-1:0]) begin
            tx_gap_r <= tx_gap_r + 1'b1;
         end
         if (tx_state_o != `SLPC_ST_LOCK) begin
            tx_lock_r <= {`SLPC_CNT_W{1'b0}};
         end else if (cap_edge) begin
            tx_lock_r <= tx_lock_r + 1'b1;
         end
         // Frames only leave in the running state
         if (tx_state_o == `SLPC_ST_RUN && cap_edge) begin
            tx_frame_o       <= enc_frame;
            tx_frame_valid_o <= 1'b1;
            tx_prev_r        <= enc_scr;
            tx_rd_r          <= enc_rd;
            tx_sh_r          <= enc_frame;
         end else begin
            tx_sh_r <= {tx_sh_r[`SLPC_FW-2:0], 1'b0};
         end
         // Serial pair idles with both legs high; leaving run drops the swing at once
         if (tx_state_o == `SLPC_ST_RUN && tx_nxt == `SLPC_ST_RUN) begin
            tx_out_p_o <= tx_sh_r[`SLPC_FW-1];
            tx_out_n_o <= ~tx_sh_r[`SLPC_FW-1];
         end else begin
            tx_out_p_o <= 1'b1;
            tx_out_n_o <= 1'b1;
         end
      end
   end

   // ---- Receive side ----
   wire [`SLPC_SW-1:0]    un;
   wire [`SLPC_DW-1:0]    rx_scr;
   wire [`SLPC_DW-1:0]    rx_dec;
   wire                   rx_good;
   reg  [`SLPC_DW-1:0]    rx_prev_r;
   reg  [`SLPC_CNT_W-1:0] rx_gap_r;
   reg  [`SLPC_CNT_W-1:0] rx_lock_r;
   reg  [1:0]             rx_nxt;

   // Undo shuffle, balance and scramble
   generate
      for (g = 0; g < `SLPC_SW; g = g + 1) begin : unshuf
         assign un[(g * `SLPC_SHUF_STEP) % `SLPC_SW] = rx_word_i[g];
      end
   endgenerate
   assign rx_scr  = un[`SLPC_PRE_DCB] ? ~un[`SLPC_DW-1:0] : un[`SLPC_DW-1:0];
   assign rx_dec  = rx_scr ^ `SLPC_MIX(rx_prev_r);
   // Word counts only with the clock pair present and the check bit right
   assign rx_good = rx_word_strobe_i & rx_word_i[`SLPC_C1] & ~rx_word_i[`SLPC_C0] & ~^un;
   assign rx_clear = (rx_state_o == `SLPC_ST_OFF);

   // Receive power state
   always @* begin
      rx_nxt = rx_state_o;
      if (!pin_r[`SLPC_PIN_RXPD]) begin
         rx_nxt = `SLPC_ST_OFF;
      end else begin
         case (rx_state_o)
            `SLPC_ST_OFF:   rx_nxt = `SLPC_ST_LOCK;
            `SLPC_ST_SLEEP: if (rx_good) rx_nxt = `SLPC_ST_LOCK;
            `SLPC_ST_LOCK: begin
               if (rx_gap_r == RX_STOP_CYC[`SLPC_CNT_W-1:0]) begin
                  rx_nxt = `SLPC_ST_SLEEP;
               end else if (rx_lock_r == `SLPC_RX_LOCK_WORDS) begin
                  rx_nxt = `SLPC_ST_RUN;
               end
            end
            `SLPC_ST_RUN: if (rx_gap_r == RX_STOP_CYC[`SLPC_CNT_W-1:0]) rx_nxt = `SLPC_ST_SLEEP;
            default:      rx_nxt = `SLPC_ST_OFF;
         endcase
      end
   end

   // Sleep leaves the configuration copy alone; only power down clears it
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_state_o             <= `SLPC_ST_OFF;
         rx_gap_r               <= {`SLPC_CNT_W{1'b0}};
         rx_lock_r              <= {`SLPC_CNT_W{1'b0}};
         rx_prev_r              <= {`SLPC_DW{1'b0}};
         rx_data_o              <= {`SLPC_DW{1'b0}};
         rx_data_oe_o           <= 1'b0;
         recovered_out_clock_o  <= 1'b0;
         rx_clock_oe_o          <= 1'b0;
         rx_lock_o              <= 1'b0;
         rx_lock_oe_o           <= 1'b0;
         rx_eq_enable_o         <= 1'b0;
         rx_eq_step_o           <= 3'h0;
         rx_data_slew_select_o  <= 1'b0;
         rx_clock_slew_select_o <= 1'b0;
         rx_output_spread_generator_o <= 4'h0;
         serial_test_out_o      <= 1'b0;
      end else begin
         rx_state_o <= rx_nxt;
         if (rx_good || rx_state_o == `SLPC_ST_OFF) begin
            rx_gap_r <= {`SLPC_CNT_W{1'b0}};
         end else if (rx_gap_r != RX_STOP_CYC[`SLPC_CNT_W-1:0]) begin
            rx_gap_r <= rx_gap_r + 1'b1;
         end
         // A bad word restarts the acquisition count
         if (rx_state_o != `SLPC_ST_LOCK || (rx_word_strobe_i && !rx_good)) begin
            rx_lock_r <= {`SLPC_CNT_W{1'b0}};
         end else if (rx_good) begin
            rx_lock_r <= rx_lock_r + 1'b1;
         end
         if (rx_good) begin
            rx_prev_r <= un[`SLPC_DW-1:0] ^ {`SLPC_DW{un[`SLPC_PRE_DCB]}};
         end
         // Configuration outputs; equaliser off whenever its low bit is clear
         rx_eq_enable_o <= rx_cfg[`SLPC_RX_EQ_ON];
         rx_eq_step_o   <= rx_cfg[`SLPC_RX_EQ_ON] ? rx_cfg[`SLPC_RX_EQ_HI:`SLPC_RX_EQ_LO] : 3'h0;
         rx_data_slew_select_o  <= rx_cfg[`SLPC_RX_DSLEW];
         rx_clock_slew_select_o <= rx_cfg[`SLPC_RX_CSLEW];
         rx_output_spread_generator_o <= rx_cfg[`SLPC_RX_SSC_HI:`SLPC_RX_SSC_LO];
         serial_test_out_o <= (rx_state_o != `SLPC_ST_OFF) & rx_cfg[`SLPC_RX_TEST]
                              & pin_r[`SLPC_PIN_EQS];
         // Output states per power state and output state select
         case (rx_state_o)
            `SLPC_ST_RUN: begin
               rx_lock_o     <= 1'b1;
               rx_lock_oe_o  <= 1'b1;
               rx_data_oe_o  <= 1'b1;
               rx_clock_oe_o <= 1'b1;
               // New data lands with the clock away from its strobe edge
               if (rx_good) begin
                  rx_data_o             <= rx_dec;
                  recovered_out_clock_o <= ~rx_cfg[`SLPC_RX_EDGE];
               end else begin
                  recovered_out_clock_o <= rx_cfg[`SLPC_RX_EDGE];
               end
            end
            `SLPC_ST_SLEEP, `SLPC_ST_LOCK: begin
               rx_lock_o             <= 1'b0;
               rx_lock_oe_o          <= 1'b1;
               rx_data_o             <= {`SLPC_DW{1'b0}};
               recovered_out_clock_o <= 1'b0;
               rx_data_oe_o          <= ~rx_cfg[`SLPC_RX_OSS];
               rx_clock_oe_o         <= ~rx_cfg[`SLPC_RX_OSS];
            end
            default: begin
               rx_lock_o             <= 1'b0;
               rx_lock_oe_o          <= 1'b0;
               rx_data_o             <= {`SLPC_DW{1'b0}};
               rx_data_oe_o          <= 1'b0;
               recovered_out_clock_o <= 1'b0;
               rx_clock_oe_o         <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** slpc_enc_unused_guard.v ***
// Spare unit kept empty; all logic lives in the other design files
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** slpc_top_sva.sv ***
// Port checker for the link power and configuration block
`timescale 1ns/1ps
`default_nettype none
module slpc_top_sva (
   input wire logic        mclk_i,
   input wire logic        nrst_i,
   input wire logic        tx_power_down_n_i,
   input wire logic        parallel_in_clock_i,
   input wire logic [27:0] tx_frame_o,
   input wire logic        tx_frame_valid_o,
   input wire logic        tx_out_p_o,
   input wire logic        tx_out_n_o,
   input wire logic [1:0]  tx_state_o,
   input wire logic [1:0]  rx_state_o,
   input wire logic        rx_lock_o,
   input wire logic        rx_data_oe_o,
   input wire logic        rx_eq_enable_o,
   input wire logic [2:0]  rx_eq_step_o
);
   logic [6:0] still_r;
   logic       pin_r;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // Cycles since the clock pin last moved, saturating
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         still_r <= 7'h00;
         pin_r   <= 1'h0;
      end else begin
         pin_r   <= parallel_in_clock_i;
         still_r <= (pin_r != parallel_in_clock_i) ? 7'h00 : still_r + {6'h00, still_r != 7'h7F};
      end
   end
   property p_pd_pair; tx_state_o == 2'h0 |-> tx_out_p_o && tx_out_n_o; endproperty
   a_pd_pair: assert property (p_pd_pair) else $error("pair low while off");
   property p_frame_c; tx_frame_valid_o |-> tx_frame_o[27:26] == 2'h2; endproperty
   a_frame_c: assert property (p_frame_c) else $error("bad clock pair");
   property p_frame_run; tx_frame_valid_o |-> $past(tx_state_o) == 2'h3; endproperty
   a_frame_run: assert property (p_frame_run) else $error("frame outside run");
   property p_lock_run; rx_lock_o |-> rx_state_o == 2'h3 || $past(rx_state_o) == 2'h3; endproperty
   a_lock_run: assert property (p_lock_run) else $error("lock outside run");
   property p_off_oe; rx_state_o == 2'h0 && $past(rx_state_o) == 2'h0 |-> !rx_data_oe_o; endproperty
   a_off_oe: assert property (p_off_oe) else $error("data driven while off");
   property p_eq_step; !rx_eq_enable_o |-> rx_eq_step_o == 3'h0; endproperty
   a_eq_step: assert property (p_eq_step) else $error("gain step while off");
   property p_stop_sleep; still_r >= 7'h38 |-> tx_state_o != 2'h3; endproperty
   a_stop_sleep: assert property (p_stop_sleep) else $error("run on stopped clock");
   property p_pd_off; !tx_power_down_n_i [*8] |-> tx_state_o == 2'h0; endproperty
   a_pd_off: assert property (p_pd_off) else $error("tx not off");
   c_tx_run: cover property (tx_frame_valid_o);
   c_rx_run: cover property ($rose(rx_lock_o));
   c_tx_sleep: cover property (tx_state_o == 2'h1);
endmodule
bind slpc_top slpc_top_sva slpc_top_sva_i (.*);
`default_nettype wire

// *** slpc_partner.sv ***
// Far side model: parallel clock source and matching frame source
`timescale 1ns/1ps
`default_nettype none
module slpc_partner (
   input  wire logic        mclk_i,
   input  wire logic        clk_run_i,
   input  wire logic        word_run_i,
   output var logic         pclk_o,
   output var logic [27:0]  word_o,
   output var logic         strobe_o
);
   logic [1:0] gap_r = 2'h0;
   initial {pclk_o, word_o, strobe_o} = '0;
   // Steady 80 ns clock, no spread; static between bursts
   always #40 if (clk_run_i) pclk_o = ~pclk_o;
   // Good frames every fourth cycle; idle line keeps toggling
   always @(negedge mclk_i) begin
      logic [24:0] p;
      p = 25'($urandom);
      gap_r <= gap_r + 2'h1;
      strobe_o <= word_run_i && gap_r == 2'h0; // Output clock far below the no-spread band
      word_o <= word_run_i ? {2'h2, p, ^p} : ~word_o;
   end
endmodule
`default_nettype wire

// *** slpc_top_tb.sv ***
// Self-checking bench for the link power and configuration block
`timescale 1ns/1ps
`default_nettype none
module slpc_top_tb;
   logic mclk_i, nrst_i, tx_power_down_n_i, parallel_in_clock_i, tx_swing_select_i, tx_edge_select_i;
   logic tx_cfg_wr_i, rx_power_down_n_i, rx_word_strobe_i, rx_eq_stream_i, rx_data_slew_select_i;
   logic rx_clock_slew_select_i, rx_output_state_select_i, rx_edge_select_i, rx_test_enable_i;
   logic rx_cfg_wr_i, tx_frame_valid_o, tx_out_p_o, tx_out_n_o, tx_swing_select_o, rx_data_oe_o;
   logic recovered_out_clock_o, rx_clock_oe_o, rx_lock_o, rx_lock_oe_o, rx_eq_enable_o;
   logic rx_data_slew_select_o, rx_clock_slew_select_o, serial_test_out_o, clk_run, word_run;
   logic [1:0]  tx_cfg_wdata_i, tx_state_o, rx_state_o;
   logic [23:0] tx_data_i, rx_data_o;
   logic [27:0] rx_word_i, tx_frame_o;
   logic [3:0]  rx_equaliser_gain_i, rx_spread_select_i, rx_output_spread_generator_o;
   logic [12:0] rx_cfg_wdata_i, w;
   logic [2:0]  rx_eq_step_o;
   int          err_total = 0, checks_done = 0, cycles = 0;
   logic [23:0] h0, h1, h2, sp = '0;
   logic        srd = 1'h0;
   slpc_top slpc_top_i (.*);
   slpc_partner slpc_partner_i (.mclk_i(mclk_i), .clk_run_i(clk_run), .word_run_i(word_run),
      .pclk_o(parallel_in_clock_i), .word_o(rx_word_i), .strobe_o(rx_word_strobe_i));
   initial mclk_i = 1'h0;
   always #4 mclk_i = ~mclk_i;
   // Random parallel data and observed stream
   always @(negedge mclk_i) {tx_data_i, rx_eq_stream_i} <= 25'($urandom);
   // Data history three edges deep, matching the capture pipeline
   always @(posedge mclk_i) {h2, h1, h0} <= {h1, h0, tx_data_i};
   always @(negedge mclk_i) if (tx_frame_valid_o === 1'h1) chk_frame();
   // Hang guard, far above the expected run length
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         finish_test();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for a state on either end
   task automatic wait_st(input logic rx, input logic [1:0] st);
      for (int i = 0; i < 800 && (rx ? rx_state_o : tx_state_o) !== st; i++) cyc(1);
      cyc(1);  // Flags are registered one edge after the state
   endtask
   task automatic cfg_wr(input logic rx, input logic [12:0] d);
      {rx_cfg_wdata_i, tx_cfg_wdata_i} = {d, d[1:0]};
      {rx_cfg_wr_i, tx_cfg_wr_i} = {rx, !rx};
      cyc(1);
      {rx_cfg_wr_i, tx_cfg_wr_i} = 2'h0;
      cyc(3);
   endtask
   function automatic logic [2:0] exp_step(input logic [3:0] g);
      return g[0] ? g[3:1] : 3'h0;
   endfunction
   // Expected frame: scramble, balance, shuffle, clock pair on top
   task automatic chk_frame;
      logic [23:0] s;
      logic [25:0] p, f;
      logic        v;
      int          n;
      s  = h2 ^ {sp[22:0], sp[23]} ^ {sp[4:0], sp[23:5]};
      n  = $countones(s);
      v  = srd ? n > 12 : n < 12;
      sp = s;
      if (v) n = 24 - n;
      if (n != 12) srd = n > 12;
      p = {1'h0, v, v ? ~s : s};
      p[25] = ^p;
      for (int g = 0; g < 26; g++) f[g] = p[g * 7 % 26];
      chk("tx frame", {2'h2, f}, tx_frame_o);
   endtask
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h8C30D721));
      {nrst_i, tx_power_down_n_i, tx_cfg_wr_i, rx_power_down_n_i, rx_cfg_wr_i, clk_run, word_run} = '0;
      {tx_cfg_wdata_i, rx_cfg_wdata_i} = '0;
      {rx_equaliser_gain_i, rx_spread_select_i, rx_output_state_select_i, rx_edge_select_i} = 10'($urandom);
      {rx_data_slew_select_i, rx_clock_slew_select_i, rx_test_enable_i} = 3'($urandom);
      {tx_swing_select_i, tx_edge_select_i} = 2'h1;  // Strap differs from the later register write
      cyc(16);
      nrst_i = 1'h1;
      // Transmit: lock, run, then swing and falling edge by register
      tx_power_down_n_i = 1'h1;
      clk_run = 1'h1;
      wait_st(0, 2'h3);
      chk("tx run", 2'h3, tx_state_o);
      cfg_wr(0, 13'h1);
      chk("tx swing", 1'h1, tx_swing_select_o);
      cyc(100);
      chk("tx falling", 2'h3, tx_state_o);
      clk_run = 1'h0;
      cyc(70);
      chk("tx sleep", 2'h1, tx_state_o);
      chk("tx pair", 2'h3, {tx_out_p_o, tx_out_n_o});
      chk("tx kept", 1'h1, tx_swing_select_o);
      clk_run = 1'h1;
      cyc(40);
      chk("tx relock", 2'h2, tx_state_o);
      tx_power_down_n_i = 1'h0;
      cyc(8);
      chk("tx off", 2'h0, tx_state_o);
      clk_run = 1'h0;
      // Receive: lock, both equaliser modes, stop, relock, power down
      rx_power_down_n_i = 1'h1;
      word_run = 1'h1;
      wait_st(1, 2'h3);
      chk("rx lock", 4'hF, {rx_lock_o, rx_lock_oe_o, rx_data_oe_o, rx_clock_oe_o});
      for (int k = 0; k < 2; k++) begin
         w = 13'($urandom);
         w[0] = k[0];
         cfg_wr(1, w);
         chk("eq step", {w[0], exp_step(w[3:0])}, {rx_eq_enable_o, rx_eq_step_o});
         chk("spread", w[7:4], rx_output_spread_generator_o);
         chk("slew", w[9:8], {rx_clock_slew_select_o, rx_data_slew_select_o});
      end
      word_run = 1'h0;
      cyc(40);
      chk("rx sleep", 2'h1, rx_state_o);
      chk("rx unlock", 1'h0, rx_lock_o);
      chk("rx oe", !w[10], rx_data_oe_o);
      chk("rx kept", exp_step(w[3:0]), rx_eq_step_o);
      word_run = 1'h1;
      wait_st(1, 2'h3);
      chk("rx relock", 1'h1, rx_lock_o);
      rx_power_down_n_i = 1'h0;
      cyc(10);
      chk("rx off oe", 3'h0, {rx_data_oe_o, rx_clock_oe_o, rx_lock_oe_o});
      chk("rx off out", 26'h0, {rx_data_o, recovered_out_clock_o, serial_test_out_o});
      chk("rx cleared", exp_step(rx_equaliser_gain_i), rx_eq_step_o);
      finish_test();
   end
endmodule
`default_nettype wire
